// file: src/ctb_picker.sv
/*
  ctb_picker: chooses the pending buffer handed to the protocol engine.
  Assumes all inputs are on ref_clk; output is combinational and is
  registered by the instantiating module.
*/
`timescale 1ns/1ps
module ctb_picker
  import ctb_pkg::*;
#(
  parameter int N = NUM_BUFFERS
) (
  input  wire logic [N-1:0]   pendIn,
  input  wire logic [2*N-1:0] priIn,
  output logic                anyOut,
  output logic [1:0]          selOut
);
  logic [2:0] bestPri;

  always_comb begin
    anyOut  = 1'b0;
    selOut  = 2'h0;
    bestPri = 3'h0;
    // ties go to the highest number, later index overwrites
    for (int i = 0; i < N; i++) begin
      if (pendIn[i] &&
          (!anyOut || {1'b0, priIn[2*i +: 2]} >= bestPri)) begin
        anyOut  = 1'b1;
        selOut  = 2'(i);
        bestPri = {1'b0, priIn[2*i +: 2]};
      end
    end
  end
endmodule

// file: src/ctb_pkg.sv
/*
  ctb_pkg: register offsets, field positions, reset values and sizes
  shared by the transmit buffer block and its buffer picker.
  Assumes an 8-bit plain register port with byte-wide registers.
*/
package ctb_pkg;
  localparam int          NUM_BUFFERS   = 3;
  localparam int          ADDR_W        = 5;
  localparam int          BUF_STRIDE    = 5;
  // per-buffer register offsets inside one buffer's window
  localparam logic [2:0]  OFS_CONTROL   = 3'h0;
  localparam logic [2:0]  OFS_ID_HIGH   = 3'h1;
  localparam logic [2:0]  OFS_ID_LOW    = 3'h2;
  localparam logic [2:0]  OFS_ID_MID    = 3'h3;
  localparam logic [2:0]  OFS_ID_BOTTOM = 3'h4;
  // common registers, above the buffer windows
  localparam logic [4:0]  OFS_IRQ_STAT  = 5'h10;
  localparam logic [4:0]  OFS_IRQ_EN    = 5'h11;
  localparam logic [4:0]  OFS_IRQ_CLR   = 5'h12;
  // control register fields
  localparam int          CTL_ABORTED   = 6;
  localparam int          CTL_LOSTARB   = 5;
  localparam int          CTL_BUSERR    = 4;
  localparam int          CTL_REQUEST   = 3;
  localparam int          CTL_PRI_HI    = 1;
  localparam int          CTL_PRI_LO    = 0;
  // id low register fields
  localparam int          IDL_BASE_HI   = 7;
  localparam int          IDL_BASE_LO   = 5;
  localparam int          IDL_EXT_SEL   = 3;
  localparam int          IDL_L17       = 1;
  localparam int          IDL_L16       = 0;
  localparam logic [7:0]  CTL_RD_MASK   = 8'h7b;
  localparam logic [7:0]  IDL_RD_MASK   = 8'heb;
  localparam logic [7:0]  RESET_CTL     = 8'h00;
  localparam logic [7:0]  RESET_ID      = 8'h00;
  localparam logic [7:0]  RESET_IRQ     = 8'h00;
  // interrupt status bits per buffer: done, then abort, lost and error sharing one bit
  localparam int          IRQ_PER_BUF   = 2;
endpackage

// file: src/ctb_tx_buffers.sv
/*
  ctb_tx_buffers: control, status and identifier registers of the CAN
  transmit buffers, with request arbitration and an interrupt output.
  Assumes a protocol engine on ref_clk that takes txValid/txId/txExt,
  answers with one-cycle pulses naming the buffer in engBuf, and a
  register master that follows the plain strobe protocol.
*/
// Notes on behaviour
// - the aborted flag sets when a pending send is dropped on abort.
// - the lost-arbitration flag sets when the frame loses arbitration.
// - writing one to send request queues it and clears the three flags.
// - send request clears itself after a successful transmission.
// - writing zero to a set send request asks for an abort.
// - two-bit priority, 3 highest, 0 lowest, higher sent first.
// - priority only orders buffers and never touches the identifier.
// - id high holds base bits 10..3, or long bits 28..21 if extended.
// - id low bits 7..5 hold base bits 2..0, or long bits 20..18.
// - extended select one gives a 29-bit identifier.
// - extended select zero gives 11 bits and ignores long bits 17..0.
// - id low bits 1..0 hold long bits 17 and 16.
// - unimplemented bits of control and id low read as zero.
// - two more bytes hold long bits 15..8 and 7..0, extended only.
`timescale 1ns/1ps
module ctb_tx_buffers
  import ctb_pkg::*;
#(
  parameter int N = NUM_BUFFERS
) (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [7:0]        regWrData,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic [7:0]             regRdData,
  output logic                   txValid,
  output logic [1:0]             txBuf,
  output logic [28:0]            txId,
  output logic                   txExt,
  input  wire logic              engStart,
  input  wire logic              engDone,
  input  wire logic              engLostArb,
  input  wire logic              engBusErr,
  input  wire logic              engAborted,
  input  wire logic [1:0]        engBuf,
  output logic                   txAbortReq,
  output logic                   irq
);
  logic [7:0]       ctl_r    [N];
  logic [7:0]       idHigh_r [N];
  logic [7:0]       idLow_r  [N];
  logic [7:0]       idMid_r  [N];
  logic [7:0]       idBot_r  [N];
  logic [N-1:0]     abortPend_r;
  logic [N-1:0]     abortDone;
  logic [2*N-1:0]   irqStat_r;
  logic [2*N-1:0]   irqEn_r;
  logic [N-1:0]     pend;
  logic [2*N-1:0]   pri;
  logic             anySel;
  logic [1:0]       sel;
  logic [1:0]       inFlight_r;
  logic             busy_r;

  function automatic logic hitBuf(input logic [ADDR_W-1:0] a,
                                  input int b, input logic [2:0] o);
    return a == ADDR_W'(b * BUF_STRIDE + int'(o));
  endfunction

  // compose the frame identifier from the buffer bytes
  function automatic logic [28:0] frameId(input logic [7:0] hi,
                                          input logic [7:0] lo,
                                          input logic [7:0] mid,
                                          input logic [7:0] bot);
    if (lo[IDL_EXT_SEL])
      return {hi, lo[IDL_BASE_HI:IDL_BASE_LO], lo[IDL_L17:IDL_L16],
              mid, bot};
    else
      // long bits are ignored entirely in standard mode
      return {18'h00000, hi, lo[IDL_BASE_HI:IDL_BASE_LO]};
  endfunction

  function automatic logic engHit(input logic p, input logic [1:0] b,
                                  input int i);
    return p && b == 2'(i);
  endfunction

  always_comb begin
    for (int i = 0; i < N; i++) begin
      pend[i]        = ctl_r[i][CTL_REQUEST] && !abortPend_r[i];
      pri[2*i +: 2]  = ctl_r[i][CTL_PRI_HI:CTL_PRI_LO];
      // abort completes: idle buffer at once, engine otherwise
      abortDone[i]   = abortPend_r[i] &&
                       (engHit(engAborted, engBuf, i) ||
                        !(busy_r && inFlight_r == 2'(i)));
    end
  end

  ctb_picker #(.N(N)) picker (
    .pendIn (pend),
    .priIn  (pri),
    .anyOut (anySel),
    .selOut (sel)
  );

  // control and status per buffer
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < N; i++)
        ctl_r[i] <= RESET_CTL;
      abortPend_r <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (regWrite && hitBuf(regAddr, i, OFS_CONTROL)) begin
          ctl_r[i][CTL_PRI_HI:CTL_PRI_LO] <=
            regWrData[CTL_PRI_HI:CTL_PRI_LO];
          if (regWrData[CTL_REQUEST]) begin
            // new request clears the status flags
            ctl_r[i][CTL_REQUEST] <= 1'b1;
            ctl_r[i][CTL_ABORTED] <= 1'b0;
            ctl_r[i][CTL_LOSTARB] <= 1'b0;
            ctl_r[i][CTL_BUSERR]  <= 1'b0;
            abortPend_r[i]        <= 1'b0;
          end else if (ctl_r[i][CTL_REQUEST]) begin
            // clearing a set request asks for an abort
            abortPend_r[i] <= 1'b1;
          end
        end
        if (engHit(engLostArb, engBuf, i))
          ctl_r[i][CTL_LOSTARB] <= 1'b1;
        if (engHit(engBusErr, engBuf, i))
          ctl_r[i][CTL_BUSERR] <= 1'b1;
        if (engHit(engDone, engBuf, i)) begin
          ctl_r[i][CTL_REQUEST] <= 1'b0;
          abortPend_r[i]        <= 1'b0;
        end
        // aborted flag sets as the abort completes
        if (abortDone[i]) begin
          ctl_r[i][CTL_REQUEST] <= 1'b0;
          ctl_r[i][CTL_ABORTED] <= 1'b1;
          abortPend_r[i]        <= 1'b0;
        end
      end
    end
  end

  // identifier bytes, plain storage
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < N; i++) begin
        idHigh_r[i] <= RESET_ID;
        idLow_r[i]  <= RESET_ID;
        idMid_r[i]  <= RESET_ID;
        idBot_r[i]  <= RESET_ID;
      end
    end else if (regWrite) begin
      for (int i = 0; i < N; i++) begin
        if (hitBuf(regAddr, i, OFS_ID_HIGH))
          idHigh_r[i] <= regWrData;
        // unimplemented id low bits are never stored
        if (hitBuf(regAddr, i, OFS_ID_LOW))
          idLow_r[i] <= regWrData & IDL_RD_MASK;
        if (hitBuf(regAddr, i, OFS_ID_MID))
          idMid_r[i] <= regWrData;
        if (hitBuf(regAddr, i, OFS_ID_BOTTOM))
          idBot_r[i] <= regWrData;
      end
    end
  end

  // hand-off to the engine; the id is latched at start so a rewrite
  // mid-frame cannot corrupt the frame in flight
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      txValid    <= 1'b0;
      txBuf      <= 2'h0;
      txId       <= 29'h0;
      txExt      <= 1'b0;
      busy_r     <= 1'b0;
      inFlight_r <= 2'h0;
      txAbortReq <= 1'b0;
    end else begin
      txAbortReq <= busy_r && abortPend_r[inFlight_r];
      if (busy_r) begin
        txValid <= 1'b0;
        if (engDone || engAborted ||
            ((engLostArb || engBusErr) && engBuf == inFlight_r))
          busy_r <= 1'b0;
      end else if (txValid && engStart) begin
        // taken: drop the offer at once and track txBuf as registered on the start edge,
        // which is a newer pick than the engine latched if sel changed on that edge
        txValid    <= 1'b0;
        busy_r     <= 1'b1;
        inFlight_r <= txBuf;
      end else begin
        txValid <= anySel;
        txBuf   <= sel;
        // priority only picks sel; id comes from the bytes alone
        txId    <= frameId(idHigh_r[sel], idLow_r[sel],
                           idMid_r[sel], idBot_r[sel]);
        txExt   <= idLow_r[sel][IDL_EXT_SEL];
      end
    end
  end

  // sticky interrupt status: done at 2i, abort/error at 2i+1
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irqStat_r <= RESET_IRQ[2*N-1:0];
      irqEn_r   <= RESET_IRQ[2*N-1:0];
    end else begin
      if (regWrite && regAddr == OFS_IRQ_EN)
        irqEn_r <= regWrData[2*N-1:0];
      for (int i = 0; i < N; i++) begin
        for (int k = 0; k < IRQ_PER_BUF; k++) begin
          // set wins over a clear in the same cycle
          if (k == 0 ? engHit(engDone, engBuf, i)
                     : (abortDone[i] ||
                        engHit(engAborted, engBuf, i) ||
                        engHit(engLostArb, engBuf, i) ||
                        engHit(engBusErr, engBuf, i)))
            irqStat_r[2*i+k] <= 1'b1;
          else if (regWrite && regAddr == OFS_IRQ_CLR &&
                   regWrData[2*i+k])
            irqStat_r[2*i+k] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      irq <= 1'b0;
    else
      irq <= |(irqStat_r & irqEn_r);
  end

  // read port: data in the cycle after the strobe only
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= 8'h00;
      if (regRead) begin
        for (int i = 0; i < N; i++) begin
          if (hitBuf(regAddr, i, OFS_CONTROL))
            regRdData <= ctl_r[i] & CTL_RD_MASK;
          if (hitBuf(regAddr, i, OFS_ID_HIGH))
            regRdData <= idHigh_r[i];
          if (hitBuf(regAddr, i, OFS_ID_LOW))
            regRdData <= idLow_r[i];
          if (hitBuf(regAddr, i, OFS_ID_MID))
            regRdData <= idMid_r[i];
          if (hitBuf(regAddr, i, OFS_ID_BOTTOM))
            regRdData <= idBot_r[i];
        end
        if (regAddr == OFS_IRQ_STAT)
          regRdData <= 8'({irqStat_r});
        if (regAddr == OFS_IRQ_EN)
          regRdData <= 8'({irqEn_r});
      end
    end
  end
endmodule

// file: tb/ctb_engine_model.sv
/* ctb_engine_model: protocol engine stand-in on the transmit side.
   Assumes ref_clk; mode 0 sends, 1 loses, 2 errors, 3 holds off. */
`timescale 1ns/1ps
module ctb_engine_model (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       txValid,
  input  wire logic [1:0] txBuf,
  input  wire logic       txAbortReq,
  input  wire logic [1:0] mode,
  input  wire logic [3:0] lat,
  output logic            engStart,
  output logic            engDone,
  output logic            engLostArb,
  output logic            engBusErr,
  output logic            engAborted,
  output logic [1:0]      engBuf
);
  logic       busy_r;
  logic [3:0] cnt_r;
  logic [1:0] buf_r;
  // buffer number is junk away from a pulse, as on the real link
  assign engBuf = (engDone | engLostArb | engBusErr | engAborted) ? buf_r
                                                                  : ~buf_r;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_r     <= 1'b0;
      cnt_r      <= 4'h0;
      buf_r      <= 2'h0;
      engStart   <= 1'b0;
      engDone    <= 1'b0;
      engLostArb <= 1'b0;
      engBusErr  <= 1'b0;
      engAborted <= 1'b0;
    end else begin
      engStart   <= 1'b0;
      engDone    <= 1'b0;
      engLostArb <= 1'b0;
      engBusErr  <= 1'b0;
      engAborted <= 1'b0;
      if (!busy_r && txValid && mode != 2'h3) begin
        engStart <= 1'b1;
        busy_r   <= 1'b1;
        cnt_r    <= 4'h0;
        buf_r    <= txBuf;
      end else if (busy_r && txAbortReq) begin
        engAborted <= 1'b1;
        busy_r     <= 1'b0;
      end else if (busy_r && cnt_r == lat && mode != 2'h3) begin
        engDone    <= (mode == 2'h0);
        engLostArb <= (mode == 2'h1);
        engBusErr  <= (mode == 2'h2);
        busy_r     <= 1'b0;
      end else if (busy_r) begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule

// file: tb/ctb_monitor.sv
/* ctb_monitor: port assertions for ctb_tx_buffers.
   Assumes one clock domain; bound in at the foot of this file. */
`timescale 1ns/1ps
module ctb_monitor
  import ctb_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              reset_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic              regWrite,
  input wire logic              regRead,
  input wire logic [7:0]        regRdData,
  input wire logic              txValid,
  input wire logic [28:0]       txId,
  input wire logic              txExt,
  input wire logic              engStart,
  input wire logic              engLostArb,
  input wire logic              txAbortReq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence sAccept;
    txValid && engStart;
  endsequence
  sequence sRetry;
    ##[1:4] txValid;
  endsequence
  a_ctl_pad_zero: assert property (regRead && regAddr == 5'h00
    |=> (regRdData & ~CTL_RD_MASK) == 8'h00) else $error("control pad set");
  a_idl_pad_zero: assert property (regRead && regAddr == 5'h02
    |=> (regRdData & ~IDL_RD_MASK) == 8'h00) else $error("id low pad set");
  a_read_slot_only: assert property (regRdData != 8'h00
    |-> $past(regRead)) else $error("read data outside its slot");
  a_std_id_narrow: assert property (txValid && !txExt
    |-> txId[28:11] == 18'h0) else $error("standard id too wide");
  a_offer_taken: assert property (sAccept
    |=> !txValid) else $error("offer kept after start");
  a_offer_holds: assert property (txValid && !engStart && !regWrite
    && !$past(regWrite) |=> txValid) else $error("offer vanished");
  a_abort_cause: assert property ($rose(txAbortReq)
    |-> $past(regWrite) || $past(regWrite, 2)) else $error("stray abort");
  a_abort_no_offer: assert property (txAbortReq
    |-> !txValid) else $error("offer during abort");
  a_lost_retry: assert property (engLostArb
    |-> sRetry) else $error("no retry after lost arbitration");
  c_accept: cover property (sAccept);
endmodule
bind ctb_tx_buffers ctb_monitor u_mon (.ref_clk, .reset_n, .regAddr,
  .regWrite, .regRead, .regRdData, .txValid, .txId, .txExt, .engStart,
  .engLostArb, .txAbortReq);

// file: tb/ctb_tx_buffers_bench.sv
/* ctb_tx_buffers_bench: self-checking bench for ctb_tx_buffers.
   Assumes ctb_engine_model as the engine and the bound monitor. */
`timescale 1ns/1ps
module ctb_tx_buffers_bench
  import ctb_pkg::*;
  ;
  logic [4:0]  regAddr;
  logic [7:0]  regWrData, regRdData;
  logic        ref_clk, reset_n, regWrite, regRead, irq, txValid, txExt;
  logic        txAbortReq, engStart, engDone, engLostArb, engBusErr;
  logic        engAborted;
  logic [1:0]  txBuf, engBuf, mode, order[$];
  logic [3:0]  lat;
  logic [28:0] txId;
  int          err_total, checked;
  ctb_tx_buffers #(.N(3)) DUT (.ref_clk, .reset_n, .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData, .txValid, .txBuf, .txId, .txExt,
    .engStart, .engDone, .engLostArb, .engBusErr, .engAborted, .engBuf,
    .txAbortReq, .irq);
  ctb_engine_model u_eng (.ref_clk, .reset_n, .txValid, .txBuf,
    .txAbortReq, .mode, .lat, .engStart, .engDone, .engLostArb,
    .engBusErr, .engAborted, .engBuf);
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [4:0] a, logic [7:0] d);
    @(posedge ref_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrite  <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(logic [4:0] a, logic [7:0] e, string nm);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 check(nm, regRdData, e);
  endtask
  task automatic waitOffer();
    for (int i = 0; i < 20 && txValid !== 1'b1; i++) begin
      @(posedge ref_clk);
    end
    #1;
    check("offer up", txValid, 1'b1);
  endtask
  task automatic t_reset();
    for (int a = 0; a < 15; a++) begin
      rd(5'(a), RESET_ID, "reset value");
    end
    wr(5'h1f, 8'hff);
    rd(5'h1f, 8'h00, "unmapped");
  endtask
  task automatic t_ident();
    mode <= 2'h3;
    wr(5'h11, 8'hff);
    wr(5'h01, 8'hab);
    wr(5'h02, 8'hf3);
    wr(5'h03, 8'h12);
    wr(5'h04, 8'h34);
    rd(5'h02, 8'he3, "id low");
    wr(5'h00, 8'hff);
    waitOffer();
    check("std id", txId, {18'h0, 8'hab, 3'h7});
    check("std ext", txExt, 1'b0);
    rd(5'h00, 8'h0b, "control");
    wr(5'h00, 8'h03);
    rd(5'h00, 8'h43, "idle abort");
    wr(5'h02, 8'he9);
    wr(5'h00, 8'h0b);
    rd(5'h00, 8'h0b, "flags clear");
    waitOffer();
    check("ext id", txId, {8'hab, 3'h7, 2'h1, 8'h12, 8'h34});
    check("ext flag", txExt, 1'b1);
    lat  <= 4'h2;
    mode <= 2'h0;
    repeat (10) @(posedge ref_clk);
    rd(5'h00, 8'h03, "sent");
    check("irq set", irq, 1'b1);
    wr(5'h11, 8'h00);
    rd(5'h11, 8'h00, "enable");
    check("irq masked", irq, 1'b0);
    wr(5'h11, 8'hff);
    rd(5'h10, 8'h03, "status");
    check("irq again", irq, 1'b1);
    wr(5'h12, 8'hff);
    rd(5'h10, 8'h00, "cleared");
    check("irq clear", irq, 1'b0);
  endtask
  always @(posedge ref_clk) begin
    if (engDone === 1'b1) begin
      order.push_back(engBuf);
    end
  end
  task automatic t_prio();
    mode <= 2'h3;
    wr(5'h00, 8'h09);
    wr(5'h05, 8'h0a);
    wr(5'h0a, 8'h0a);
    waitOffer();
    repeat (3) @(posedge ref_clk);
    check("tie pick", txBuf, 2'h2);
    wr(5'h0a, 8'h08);
    repeat (3) @(posedge ref_clk);
    check("prio pick", txBuf, 2'h1);
    order = {};
    lat  <= 4'h1;
    mode <= 2'h0;
    repeat (30) @(posedge ref_clk);
    check("send order", {order[0], order[1], order[2]}, 6'h12);
  endtask
  task automatic t_fault();
    mode <= 2'h1;
    wr(5'h00, 8'h08);
    repeat (10) @(posedge ref_clk);
    mode <= 2'h2;
    repeat (10) @(posedge ref_clk);
    lat  <= 4'hf;
    mode <= 2'h0;
    rd(5'h00, 8'h38, "lost and error");
    wr(5'h00, 8'h00);
    repeat (4) @(posedge ref_clk);
    rd(5'h00, 8'h70, "flight abort");
    wr(5'h00, 8'h08);
    rd(5'h00, 8'h08, "requeue");
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    #(40 * 4000);
    err_total++;
    conclude();
  end
  initial begin
    reset_n   = 1'b0;
    regAddr   = 5'h00;
    regWrData = 8'h00;
    regWrite  = 1'b0;
    regRead   = 1'b0;
    mode      = 2'h3;
    lat       = 4'h1;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset();
    t_ident();
    t_prio();
    t_fault();
    conclude();
  end
endmodule
